// *** ctm_pkg.sv ***
package ctm_pkg;

	// ==========================================================================
	// Register byte addresses on the AXI4-Lite bus.
	localparam logic [4:0] ADDR_CTRL0 = 5'h00;
	localparam logic [4:0] ADDR_CTRL1 = 5'h04;
	localparam logic [4:0] ADDR_CNT_LO = 5'h08;
	localparam logic [4:0] ADDR_CNT_HI = 5'h0C;
	localparam logic [4:0] ADDR_CMPA_LO = 5'h10;
	localparam logic [4:0] ADDR_CMPA_HI = 5'h14;

	// ==========================================================================
	// Field positions and reset values.
	localparam int PAUSE_BIT = 7;
	localparam int CKSEL_LSB = 4;
	localparam int RUN_BIT = 3;
	localparam int MODE_LSB = 6;
	localparam int OFUNC_LSB = 4;
	localparam int OCTL_BIT = 3;
	localparam int POL_BIT = 2;
	localparam int DPX_BIT = 1;
	localparam int CCLR_BIT = 0;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// ==========================================================================
	// Prescaler ratios for the internal clock sources.
	localparam int SYS_DIV = 4;
	localparam int HI_DIV16 = 16;
	localparam int HI_DIV64 = 64;

	typedef enum logic [1:0] {
		CTM_MODE_CMP,
		CTM_MODE_UNDEF,
		CTM_MODE_PWM,
		CTM_MODE_TIMER
	} ctm_mode_t;

endpackage

// *** ctm_tick_gen.sv ***
module ctm_tick_gen (
	// Clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// Source select and raw sources
	input  wire logic [2:0] clock_select_field,
	input  wire logic       high_clk_tick,
	input  wire logic       sub_clk_tick,
	input  wire logic       external_clock_pin,
	// Counter clock tick
	output logic            tick
);

	logic [5:0] sys_div_q;
	logic [5:0] hi_div_q;
	logic       ext_q;
	logic       tick_d;
	wire        ext_rise = external_clock_pin & ~ext_q;
	wire        ext_fall = ~external_clock_pin & ext_q;
	wire        sys4     = (sys_div_q[1:0] == 2'(ctm_pkg::SYS_DIV - 1));
	wire        hi16     = high_clk_tick & (hi_div_q[3:0] == 4'(ctm_pkg::HI_DIV16 - 1));
	wire        hi64     = high_clk_tick & (hi_div_q == 6'(ctm_pkg::HI_DIV64 - 1));

	always_comb begin
		case (clock_select_field)
			3'h0: tick_d = sys4;
			3'h1: tick_d = 1'b1;
			3'h2: tick_d = hi16;
			3'h3: tick_d = hi64;
			3'h4, 3'h5: tick_d = sub_clk_tick;
			3'h6: tick_d = ext_rise;
			default: tick_d = ext_fall;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sys_div_q <= 6'h00;
			hi_div_q  <= 6'h00;
			ext_q     <= 1'b0;
			tick      <= 1'b0;
		end else begin
			sys_div_q <= sys_div_q + 6'h01;
			if (high_clk_tick) begin
				hi_div_q <= hi_div_q + 6'h01;
			end
			ext_q <= external_clock_pin;
			tick  <= tick_d;
		end
	end

endmodule // ctm_tick_gen

// *** ctm_pair_buf.sv ***
module ctm_pair_buf (
	// Clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// Bus side events
	input  wire logic       wr_cmpa_lo,
	input  wire logic       wr_cmpa_hi,
	input  wire logic       rd_cnt_hi,
	input  wire logic       rd_cmpa_hi,
	input  wire logic [7:0] wdata,
	input  wire logic [9:0] counter,
	// Stored values
	output logic [9:0]      compare_a_value,
	output logic [7:0]      hold_buf
);

	// A single buffer is shared by both pairs, so interleaving pair accesses
	// corrupts the low byte; software must keep each sequence together.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			compare_a_value <= 10'h000;
			hold_buf        <= 8'h00;
		end else begin
			if (wr_cmpa_lo) begin
				hold_buf <= wdata;
			end else if (rd_cnt_hi) begin
				hold_buf <= counter[7:0];
			end else if (rd_cmpa_hi) begin
				hold_buf <= compare_a_value[7:0];
			end
			if (wr_cmpa_hi) begin
				compare_a_value <= {wdata[1:0], hold_buf};
			end
		end
	end

endmodule // ctm_pair_buf

// *** ctm_timer.sv ***
// Overview of operation
// - Compare-A low byte write only loads the shared holding buffer.
// - Compare-A high byte write loads high bits and copies buffer into low.
// - High byte read returns high bits and latches low byte into buffer.
// - Ten-bit up counter advances on each selected counter clock tick.
// - Comparator P uses counter bits 9..7; comparator A uses all bits.
// - Counter is never written; cleared by run rising edge, overflow, match.
// - Pause bit holds the counter; clearing it resumes from held value.
// - Clock select picks sys/4, sys, high/16, high/64, sub, pin edges.
// - Run bit low stops counting; rising edge zeroes the counter.
// - Run rising edge restores output initial level in compare mode; PWM level ignores it.
// - Period code gives code times 128 clocks; zero gives 1024.
// - Outside PWM mode, clear-select zero clears on P match, or overflow when code zero.
// - Mode field selects compare output, undefined, PWM, timer/counter.
// - Compare mode A match: no change, low, high or toggle.
// - PWM mode output function: inactive, active, waveform, undefined.
// - A match requesting the present initial level leaves the pin unchanged.
// - Output control sets initial level or PWM active level.
// - Polarity bit inverts the output pin in every mode, timer mode included.
// - Period/duty select swaps period and duty roles in PWM mode.
// - Timer/counter mode does not drive the output pin.
// - Outside PWM mode, clear-select one clears on A match and suppresses P flag.
// - Compare-A zero overflows at maximum without raising A flag.
// - PWM duty at or above period gives full duty.
module ctm_timer (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write address
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [4:0]  s_axi_awaddr,
	// AXI4-Lite write data
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	// AXI4-Lite write response
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	// AXI4-Lite read address
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [4:0]  s_axi_araddr,
	// AXI4-Lite read data
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	// Clock sources
	input  wire logic        high_clk_tick,
	input  wire logic        sub_clk_tick,
	input  wire logic        external_clock_pin,
	// Timer outputs
	output logic             timer_output_pin,
	output logic             timer_output_pin_inverted,
	output logic             timer_output_en,
	output logic             compare_a_flag,
	output logic             compare_p_flag
);

	// ==========================================================================
	// Register bus slave.
	logic [7:0]  ctrl0_q;
	logic [7:0]  ctrl1_q;
	logic [4:0]  awaddr_q;
	logic [7:0]  wdata_q;
	logic        wstrb_q;
	logic        aw_held_q;
	logic        w_held_q;
	logic [9:0]  cnt_q;
	logic [9:0]  cmpa;
	logic [7:0]  hold_buf;
	logic        run_q;
	logic        outlvl_q;
	logic        tick;

	wire         wr_fire  = aw_held_q & w_held_q & ~s_axi_bvalid;
	wire         rd_fire  = s_axi_arvalid & s_axi_arready;
	wire         wr_c0    = wr_fire & wstrb_q & (awaddr_q == ctm_pkg::ADDR_CTRL0);
	wire         wr_c1    = wr_fire & wstrb_q & (awaddr_q == ctm_pkg::ADDR_CTRL1);
	wire         wr_al    = wr_fire & wstrb_q & (awaddr_q == ctm_pkg::ADDR_CMPA_LO);
	wire         wr_ah    = wr_fire & wstrb_q & (awaddr_q == ctm_pkg::ADDR_CMPA_HI);
	wire         rd_dh    = rd_fire & (s_axi_araddr == ctm_pkg::ADDR_CNT_HI);
	wire         rd_ah    = rd_fire & (s_axi_araddr == ctm_pkg::ADDR_CMPA_HI);
	wire         wr_known = (awaddr_q == ctm_pkg::ADDR_CTRL0) |
	                        (awaddr_q == ctm_pkg::ADDR_CTRL1) |
	                        (awaddr_q == ctm_pkg::ADDR_CNT_LO) |
	                        (awaddr_q == ctm_pkg::ADDR_CNT_HI) |
	                        (awaddr_q == ctm_pkg::ADDR_CMPA_LO) |
	                        (awaddr_q == ctm_pkg::ADDR_CMPA_HI);
	logic [7:0]  rd_byte;
	logic        rd_ok;

	always_comb begin
		rd_ok = 1'b1;
		if (s_axi_araddr == ctm_pkg::ADDR_CTRL0) begin
			rd_byte = ctrl0_q;
		end else if (s_axi_araddr == ctm_pkg::ADDR_CTRL1) begin
			rd_byte = ctrl1_q;
		end else if (s_axi_araddr == ctm_pkg::ADDR_CNT_LO) begin
			rd_byte = hold_buf;
		end else if (s_axi_araddr == ctm_pkg::ADDR_CNT_HI) begin
			rd_byte = {6'h00, cnt_q[9:8]};
		end else if (s_axi_araddr == ctm_pkg::ADDR_CMPA_LO) begin
			rd_byte = hold_buf;
		end else if (s_axi_araddr == ctm_pkg::ADDR_CMPA_HI) begin
			rd_byte = {6'h00, cmpa[9:8]};
		end else begin
			rd_byte = 8'h00;
			rd_ok   = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			aw_held_q     <= 1'b0;
			w_held_q      <= 1'b0;
			awaddr_q      <= 5'h00;
			wdata_q       <= 8'h00;
			wstrb_q       <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'h0;
		end else begin
			if (s_axi_awvalid & s_axi_awready) begin
				awaddr_q      <= s_axi_awaddr;
				aw_held_q     <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				wdata_q      <= s_axi_wdata[7:0];
				wstrb_q      <= s_axi_wstrb[0];
				w_held_q     <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_known ? 2'h0 : 2'h2;
				aw_held_q    <= 1'b0;
				w_held_q     <= 1'b0;
			end
			if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= 2'h0;
		end else if (rd_fire) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= {24'h00_0000, rd_byte};
			s_axi_rresp   <= rd_ok ? 2'h0 : 2'h2;
		end else if (s_axi_rvalid & s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl0_q <= ctm_pkg::CTRL_RESET;
			ctrl1_q <= ctm_pkg::CTRL_RESET;
		end else begin
			if (wr_c0) begin
				ctrl0_q <= wdata_q;
			end
			if (wr_c1) begin
				ctrl1_q <= wdata_q;
			end
		end
	end

	ctm_pair_buf u_pair (
		.aclk            (aclk),
		.aresetn         (aresetn),
		.wr_cmpa_lo      (wr_al),
		.wr_cmpa_hi      (wr_ah),
		.rd_cnt_hi       (rd_dh),
		.rd_cmpa_hi      (rd_ah),
		.wdata           (wdata_q),
		.counter         (cnt_q),
		.compare_a_value (cmpa),
		.hold_buf        (hold_buf)
	);

	ctm_tick_gen u_tick (
		.aclk               (aclk),
		.aresetn            (aresetn),
		.clock_select_field (ctrl0_q[ctm_pkg::CKSEL_LSB +: 3]),
		.high_clk_tick      (high_clk_tick),
		.sub_clk_tick       (sub_clk_tick),
		.external_clock_pin (external_clock_pin),
		.tick               (tick)
	);

	// ==========================================================================
	// Counter and comparators.
	wire         pause_bit   = ctrl0_q[ctm_pkg::PAUSE_BIT];
	wire         run_bit     = ctrl0_q[ctm_pkg::RUN_BIT];
	wire  [2:0]  period_code = ctrl0_q[2:0];
	wire  [1:0]  mode_field  = ctrl1_q[ctm_pkg::MODE_LSB +: 2];
	wire  [1:0]  ofunc       = ctrl1_q[ctm_pkg::OFUNC_LSB +: 2];
	wire         octl        = ctrl1_q[ctm_pkg::OCTL_BIT];
	wire         pol         = ctrl1_q[ctm_pkg::POL_BIT];
	wire         dpx         = ctrl1_q[ctm_pkg::DPX_BIT];
	wire         cclr        = ctrl1_q[ctm_pkg::CCLR_BIT];
	wire         is_pwm      = (mode_field == 2'(ctm_pkg::CTM_MODE_PWM));
	wire         is_cmp      = (mode_field == 2'(ctm_pkg::CTM_MODE_CMP));
	wire         is_tmr      = (mode_field == 2'(ctm_pkg::CTM_MODE_TIMER));
	wire         run_rise    = run_bit & ~run_q;
	wire         step        = tick & run_bit & ~pause_bit & ~run_rise;
	wire  [9:0]  cnt_nx      = cnt_q + 10'h001;
	wire         a_hit       = step & (cmpa != 10'h000) & (cnt_nx == cmpa);
	// Code zero matches when the counter wraps, which gives the 1024-clock period.
	wire         p_hit       = step & (cnt_nx[9:7] == period_code) &
	                           (cnt_nx[6:0] == 7'h00);
	wire         ovf         = step & (cnt_q == 10'h3FF);
	// In PWM mode the period register clears the counter; the select bit picks it.
	wire         clr_by_a    = is_pwm ? dpx : cclr;
	wire         cnt_clr     = clr_by_a ? a_hit : (p_hit | (period_code == 3'h0 & ovf));
	wire         p_flag_d    = p_hit & ~(cclr & ~is_pwm);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q          <= 10'h000;
			run_q          <= 1'b0;
			compare_a_flag <= 1'b0;
			compare_p_flag <= 1'b0;
		end else begin
			run_q          <= run_bit;
			compare_a_flag <= a_hit;
			compare_p_flag <= p_flag_d;
			if (run_rise) begin
				cnt_q <= 10'h000;
			end else if (step) begin
				cnt_q <= cnt_clr ? 10'h000 : cnt_nx;
			end
		end
	end

	// ==========================================================================
	// Output pin.
	// Duty and period are widened to eleven bits so code zero means 1024.
	wire  [10:0] p_len   = (period_code == 3'h0) ? 11'h400 : {1'b0, period_code, 7'h00};
	wire  [10:0] a_len   = {1'b0, cmpa};
	wire  [10:0] duty    = dpx ? p_len : a_len;
	wire  [10:0] period  = dpx ? a_len : p_len;
	wire         pwm_on  = (duty >= period) | ({1'b0, cnt_q} < duty);
	logic        pwm_lvl;

	always_comb begin
		case (ofunc)
			2'h0: pwm_lvl = ~octl;
			2'h1: pwm_lvl = octl;
			2'h2: pwm_lvl = pwm_on ? octl : ~octl;
			default: pwm_lvl = ~octl;
		endcase
	end

	logic        cmp_lvl;

	always_comb begin
		cmp_lvl = outlvl_q;
		if (run_rise) begin
			cmp_lvl = octl;
		end else if (a_hit) begin
			case (ofunc)
				2'h1: cmp_lvl = 1'b0;
				2'h2: cmp_lvl = 1'b1;
				2'h3: cmp_lvl = ~outlvl_q;
				default: cmp_lvl = outlvl_q;
			endcase
		end
	end

	wire         lvl_d = is_pwm ? pwm_lvl : cmp_lvl;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			outlvl_q                  <= 1'b0;
			timer_output_pin          <= 1'b0;
			timer_output_pin_inverted <= 1'b1;
			timer_output_en           <= 1'b0;
		end else begin
			outlvl_q                  <= is_cmp ? cmp_lvl : octl;
			timer_output_pin          <= lvl_d ^ pol;
			timer_output_pin_inverted <= ~(lvl_d ^ pol);
			timer_output_en           <= ~is_tmr & (is_cmp | is_pwm);
		end
	end

	// ==========================================================================
	// Checks.
	a_run_clear: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(run_bit) |=> (cnt_q == 10'h000))
		else $error("counter not zeroed on run rising edge");
	a_pause_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		(pause_bit & run_q & $past(run_q)) |=> $stable(cnt_q))
		else $error("counter moved while paused");
	a_stop_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		(!run_bit && !$rose(run_bit)) |=> $stable(cnt_q))
		else $error("counter moved while stopped");
	a_a_flag_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
		compare_a_flag |-> (cnt_q == $past(cmpa)) || (cnt_q == 10'h000))
		else $error("compare A flag without match");
	a_a_zero_noflag: assert property (@(posedge aclk) disable iff (!aresetn)
		(cmpa == 10'h000) |=> !compare_a_flag)
		else $error("A flag raised with zero compare value");
	a_p_suppress: assert property (@(posedge aclk) disable iff (!aresetn)
		(cclr & is_cmp) |=> !compare_p_flag)
		else $error("P flag with clear select set");
	a_timer_no_drive: assert property (@(posedge aclk) disable iff (!aresetn)
		is_tmr |=> !timer_output_en)
		else $error("pin driven in timer mode");
	a_pin_pair: assert property (@(posedge aclk) disable iff (!aresetn)
		timer_output_pin != timer_output_pin_inverted)
		else $error("output pins not complementary");
	a_lo_write_buf: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_al |=> (hold_buf == $past(wdata_q)) && $stable(cmpa))
		else $error("low write changed compare value");
	a_hi_write_copy: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_ah |=> cmpa == {$past(wdata_q[1:0]), $past(hold_buf)})
		else $error("high write did not copy buffer");
	a_cmp_init: assert property (@(posedge aclk) disable iff (!aresetn)
		(is_cmp & run_rise) |=> ##1 (timer_output_pin == ($past(octl, 2) ^ $past(pol, 2))))
		else $error("output not restored to initial level");

	c_a_match: cover property (@(posedge aclk) disable iff (!aresetn) compare_a_flag);
	c_p_match: cover property (@(posedge aclk) disable iff (!aresetn) compare_p_flag);
	c_pwm_run: cover property (@(posedge aclk) disable iff (!aresetn) is_pwm & step);
	c_ovf: cover property (@(posedge aclk) disable iff (!aresetn) ovf);

endmodule // ctm_timer

// *** tb.sv ***
module tb;
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================================
	// Stimulus signals and bookkeeping
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        hi_tick, sub_tick, ext_pin;
	logic [4:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd_q;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, resp_q;
	logic        awready, wready, bvalid, arready, rvalid;
	logic        pin, pin_n, pin_en, fa, fp;
	int          n_errors, compares, cyc, gap, hits;

	ctm_timer DUT (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .high_clk_tick(hi_tick),
		.sub_clk_tick(sub_tick), .external_clock_pin(ext_pin),
		.timer_output_pin(pin), .timer_output_pin_inverted(pin_n),
		.timer_output_en(pin_en), .compare_a_flag(fa), .compare_p_flag(fp)
	);

	always #2.5 aclk = ~aclk;

	// The external source toggles every cycle, so each edge kind recurs every two cycles.
	// The high source pulses every second cycle and the sub source every fourth.
	always @(posedge aclk) begin
		ext_pin <= aresetn ? ~ext_pin : 1'b0;
		hi_tick <= cyc[0];
		sub_tick <= (cyc[1:0] == 2'h3);
		cyc <= cyc + 1;
		if (cyc == 100000) begin
			n_errors++;
			summarize();
		end
	end

	// ==========================================================================
	// Shared tasks
	task automatic summarize();
		if (n_errors == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		bit aw_d, w_d;
		aw_d = 0;
		w_d = 0;
		awaddr <= a;
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_d && w_d)) begin
			@(posedge aclk);
			if (awvalid && awready) begin
				aw_d = 1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready) begin
				w_d = 1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (!bvalid);
		resp_q = bresp;
	endtask

	task automatic rd(input logic [4:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
		end while (!rvalid);
		rd_q = rdata;
		resp_q = rresp;
	endtask

	// Run is dropped before the mode or output function changes, then raised last.
	task automatic setup(input logic [7:0] c0, input logic [7:0] c1, input logic [9:0] a);
		wr(ctm_pkg::ADDR_CTRL0, c0 & 8'hF7);
		wr(ctm_pkg::ADDR_CTRL1, c1);
		wr(ctm_pkg::ADDR_CMPA_LO, a[7:0]);
		wr(ctm_pkg::ADDR_CMPA_HI, {6'h00, a[9:8]});
		wr(ctm_pkg::ADDR_CTRL0, c0);
	endtask

	task automatic flag_gap(input bit p, input int maxc);
		gap = 0;
		do begin @(posedge aclk); gap++; end while (!(p ? fp : fa) && gap < maxc);
		gap = 0;
		do begin @(posedge aclk); gap++; end while (!(p ? fp : fa) && gap < maxc);
	endtask

	// ==========================================================================
	// Scenarios
	task automatic t_regs();
		rd(ctm_pkg::ADDR_CTRL0);
		chk(rd_q, 32'h00000000, "ctrl0 reset");
		rd(ctm_pkg::ADDR_CTRL1);
		chk(rd_q, 32'h00000000, "ctrl1 reset");
		rd(5'h18);
		chk({rd_q[7:0], 6'h00, resp_q}, 32'h00000002, "unmapped read");
		wr(5'h1C, 8'hFF);
		chk({30'h0, resp_q}, 32'h00000002, "unmapped write");
		wstrb <= 4'h0;
		wr(ctm_pkg::ADDR_CTRL1, 8'hFF);
		wstrb <= 4'hF;
		rd(ctm_pkg::ADDR_CTRL1);
		chk(rd_q, 32'h00000000, "write with strobe off");
		wr(ctm_pkg::ADDR_CMPA_LO, 8'hA5);
		rd(ctm_pkg::ADDR_CMPA_HI);
		rd(ctm_pkg::ADDR_CMPA_LO);
		chk(rd_q, 32'h00000000, "low write reached active byte");
		wr(ctm_pkg::ADDR_CMPA_LO, 8'hA5);
		wr(ctm_pkg::ADDR_CMPA_HI, 8'h02);
		rd(ctm_pkg::ADDR_CMPA_HI);
		chk(rd_q, 32'h00000002, "compare high");
		rd(ctm_pkg::ADDR_CMPA_LO);
		chk(rd_q, 32'h000000A5, "compare low via buffer");
	endtask

	task automatic t_hold();
		logic [31:0] v;
		setup(8'h19, 8'hC0, 10'h000);
		repeat (300) @(posedge aclk);
		wr(ctm_pkg::ADDR_CTRL0, 8'h99);
		rd(ctm_pkg::ADDR_CNT_HI);
		rd(ctm_pkg::ADDR_CNT_LO);
		v = rd_q;
		wr(ctm_pkg::ADDR_CNT_LO, 8'h00);
		repeat (40) @(posedge aclk);
		rd(ctm_pkg::ADDR_CNT_HI);
		rd(ctm_pkg::ADDR_CNT_LO);
		chk(rd_q, v, "paused counter moved");
		chk({31'h0, v == 0}, 32'h00000000, "counter never ran");
		wr(ctm_pkg::ADDR_CTRL0, 8'h91);
		wr(ctm_pkg::ADDR_CTRL0, 8'h99);
		rd(ctm_pkg::ADDR_CNT_HI);
		rd(ctm_pkg::ADDR_CNT_LO);
		chk(rd_q, 32'h00000000, "run rise did not zero");
		chk({31'h0, pin_en}, 32'h00000000, "pin driven in timer mode");
	endtask

	task automatic t_clocks();
		int div [8] = '{4, 1, 32, 128, 4, 4, 2, 2};
		for (int s = 0; s < 8; s++) begin
			setup({1'b0, 3'(s), 4'h9}, 8'hC0, 10'h3FF);
			flag_gap(1, 20000);
			chk(gap, 128 * div[s], "period by clock select");
		end
		setup(8'h1C, 8'hC0, 10'h3FF);
		flag_gap(1, 1000);
		chk(gap, 512, "code four period");
		setup(8'h18, 8'hC0, 10'h3FF);
		flag_gap(1, 2000);
		chk(gap, 1024, "overflow period");
		setup(8'h19, 8'hC1, 10'h100);
		flag_gap(0, 1000);
		chk(gap, 256, "A clear period");
		flag_gap(1, 600);
		chk(gap, 600, "P flag with A clear");
		setup(8'h18, 8'hC1, 10'h000);
		flag_gap(0, 1100);
		chk(gap, 1100, "A flag at zero compare");
	endtask

	task automatic t_compare();
		logic [4:0] tbl [5] = '{5'h19, 5'h0C, 5'h12, 5'h15, 5'h03};
		for (int i = 0; i < 5; i++) begin
			setup(8'h18, {2'b00, tbl[i][4:3], tbl[i][2], tbl[i][1], 2'b00}, 10'h020);
			repeat (3) @(posedge aclk);
			chk({pin, pin_n, pin_en}, {tbl[i][2] ^ tbl[i][1], ~(tbl[i][2] ^ tbl[i][1]),
				1'b1}, "initial level");
			flag_gap(0, 100);
			repeat (2) @(posedge aclk);
			chk({31'h0, pin}, {31'h0, tbl[i][0]}, "level after match");
		end
	endtask

	task automatic t_pwm();
		logic [7:0] c1 [5] = '{8'hA8, 8'hAA, 8'hA8, 8'h88, 8'h98};
		logic [9:0] av [5] = '{10'h020, 10'h100, 10'h200, 10'h020, 10'h020};
		int         exp [5] = '{64, 128, 256, 0, 256};
		for (int i = 0; i < 5; i++) begin
			setup(8'h19, c1[i], av[i]);
			repeat (300) @(posedge aclk);
			hits = 0;
			for (int k = 0; k < 256; k++) begin
				@(posedge aclk);
				hits += int'(pin);
			end
			chk(hits, exp[i], "PWM high count");
		end
		setup(8'h19, 8'hAC, 10'h020);
		repeat (300) @(posedge aclk);
		hits = 0;
		for (int k = 0; k < 256; k++) begin
			@(posedge aclk);
			hits += int'(pin);
		end
		chk(hits, 192, "inverted PWM count");
	endtask

	// ==========================================================================
	// Main sequence
	initial begin
		aclk = 0;
		aresetn = 0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		awaddr = '0;
		araddr = '0;
		wdata = '0;
		wstrb = 4'hF;
		n_errors = 0;
		compares = 0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_regs();
		t_hold();
		t_clocks();
		t_compare();
		t_pwm();
		summarize();
	end
endmodule // tb
